/* verilog/drs_pkg.sv */
`default_nettype none
package drs_pkg;

  // Bus geometry
  localparam int DRS_ADDR_W = 4;
  localparam int DRS_DATA_W = 32;
  localparam int DRS_TIMER_W = 32;

  // Register byte offsets
  localparam logic [3:0] DRS_OFF_CMD = 4'h0;
  localparam logic [3:0] DRS_OFF_CFG = 4'h4;
  localparam logic [3:0] DRS_OFF_STAT = 4'h8;

  // Command register fields
  localparam int DRS_CMD_RUN = 0;
  localparam int DRS_CMD_INCH = 1;
  localparam int DRS_CMD_ENABLE = 2;
  localparam int DRS_CMD_COAST_N = 3;
  localparam int DRS_CMD_QUICK_N = 4;
  localparam int DRS_CMD_FAULT_CLR = 5;
  localparam logic [31:0] DRS_CMD_RESET = 32'h0000_0000;
  localparam logic [31:0] DRS_CMD_MASK = 32'h0000_003F;

  // Configuration register fields
  localparam int DRS_CFG_QH_COAST = 0;
  localparam logic [31:0] DRS_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] DRS_CFG_MASK = 32'h0000_0001;

  // Status register fields
  localparam int DRS_ST_CODE_LSB = 0;
  localparam int DRS_ST_TRIPPED = 3;
  localparam int DRS_ST_RUNNING = 4;
  localparam int DRS_ST_INCHING = 5;
  localparam int DRS_ST_STOPPING = 6;
  localparam int DRS_ST_CONTACTOR = 7;
  localparam int DRS_ST_SW_ON_EN = 8;
  localparam int DRS_ST_SWITCHED_ON = 9;
  localparam int DRS_ST_READY = 10;
  localparam int DRS_ST_HEALTHY = 11;

  // AXI responses
  localparam logic [1:0] DRS_RESP_OKAY = 2'h0;
  localparam logic [1:0] DRS_RESP_DECERR = 2'h3;

  // Timing
  localparam longint DRS_CLK_HZ = 64'd50_000_000;
  localparam longint DRS_CONT_WAIT_S = 64'd10;
  localparam longint DRS_CONT_WAIT_CYC = DRS_CLK_HZ * DRS_CONT_WAIT_S;
  localparam longint DRS_QH_WAIT_MS = 64'd2000;
  localparam longint DRS_QH_WAIT_CYC = DRS_CLK_HZ * DRS_QH_WAIT_MS / 64'd1000;

  // Main states, coded 0..7 in order
  typedef enum logic [2:0] {
    DRS_START_DIS,
    DRS_START_EN,
    DRS_SWITCHED_ON,
    DRS_READY,
    DRS_ENABLED,
    DRS_QHALT,
    DRS_TRIP_ACTIVE,
    DRS_TRIPPED
  } drs_state_e;

  // Transition numbers, lower wins
  localparam int DRS_T_SD_TRIP = 2;
  localparam int DRS_T_SD_SE = 3;
  localparam int DRS_T_SE_TRIP = 4;
  localparam int DRS_T_SE_SD = 5;
  localparam int DRS_T_SE_SO = 6;
  localparam int DRS_T_SO_TRIP = 7;
  localparam int DRS_T_SO_SD = 8;
  localparam int DRS_T_SO_SE = 9;
  localparam int DRS_T_SO_RDY = 10;
  localparam int DRS_T_RDY_TRIP = 11;
  localparam int DRS_T_RDY_SD = 12;
  localparam int DRS_T_RDY_SE = 13;
  localparam int DRS_T_RDY_EN = 14;
  localparam int DRS_T_EN_TRIP = 15;
  localparam int DRS_T_EN_SD = 16;
  localparam int DRS_T_EN_QH = 17;
  localparam int DRS_T_EN_SE = 18;
  localparam int DRS_T_EN_RDY = 19;
  localparam int DRS_T_QH_TRIP = 20;
  localparam int DRS_T_QH_SD = 21;
  localparam int DRS_T_TA_TD = 22;
  localparam int DRS_T_TD_SD = 23;
  localparam int DRS_T_N = 24;

endpackage : drs_pkg
`default_nettype wire

/* verilog/drs_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module drs_timer
  import drs_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Control
  input wire logic count_en,
  input wire logic [DRS_TIMER_W-1:0] limit,
  // Result
  output logic expired
);

  logic [DRS_TIMER_W-1:0] count_r;

  // Restarts whenever count_en drops, so each state visit times afresh
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
    end else if (ce) begin
      if (!count_en) begin
        count_r <= '0;
      end else if (count_r != limit) begin
        count_r <= count_r + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expired <= 1'b0;
    end else if (ce) begin
      expired <= count_en && (count_r == limit);
    end
  end

endmodule : drs_timer
`default_nettype wire

/* verilog/drs_axil_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module drs_axil_regs
  import drs_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [DRS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DRS_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [DRS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DRS_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register contents
  output logic [DRS_DATA_W-1:0] cmd_r,
  output logic [DRS_DATA_W-1:0] cfg_r,
  input wire logic [DRS_DATA_W-1:0] status
);

  logic aw_hold_r;
  logic w_hold_r;
  logic [DRS_ADDR_W-1:0] awaddr_r;
  logic [DRS_DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb,
                                        input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction : merge

  assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;

  // Write channels accepted in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DRS_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == DRS_OFF_CMD || awaddr_r == DRS_OFF_CFG ||
                        awaddr_r == DRS_OFF_STAT) ? DRS_RESP_OKAY
                                                  : DRS_RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Status is read-only; writes to it are accepted and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= DRS_CMD_RESET;
      cfg_r <= DRS_CFG_RESET;
    end else if (ce && do_write) begin
      if (awaddr_r == DRS_OFF_CMD) begin
        cmd_r <= merge(cmd_r, wdata_r, wstrb_r, DRS_CMD_MASK);
      end
      if (awaddr_r == DRS_OFF_CFG) begin
        cfg_r <= merge(cfg_r, wdata_r, wstrb_r, DRS_CFG_MASK);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= DRS_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= DRS_RESP_OKAY;
        case (s_axi_araddr)
          DRS_OFF_CMD: s_axi_rdata <= cmd_r;
          DRS_OFF_CFG: s_axi_rdata <= cfg_r;
          DRS_OFF_STAT: s_axi_rdata <= status;
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= DRS_RESP_DECERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : drs_axil_regs
`default_nettype wire

/* verilog/drs_sequencer.sv */
// Behaviour
// - Main state reported as code 0..7
// - Tripped, running, stopping follow state table
// - Enable, switched-on, ready per state; healthy latched in tripped, contactor held in the two start states
// - Inching set at inch start, cleared at end
// - Stopping during run/inch fall or quick-halt
// - Tripped: healthy once run and inch false
// - Power-up or config reload enters start-disabled
// - Trip, or lost contactor in ready, enabled or quick-halt, goes to trip-active
// - Switched-on trips after 10 s without contactor
// - Idle commands, halts high: start-enabled
// - Halt low in start-enabled to ready returns to start-disabled; in enabled, coast low does, quick low goes to quick-halt
// - Run or inch moves start-enabled to switched-on
// - Run and inch false returns to start-enabled
// - Contactor and deflux to ready; enable toggles enabled
// - Enabled idle and stop done: start-enabled
// - Quick-halt timer, coast mode or zero setpoint exits
// - Quench to tripped; clear edge without trip resets
// - Lowest-numbered transition wins
// - Transitions fire on cause rising within state
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer
  import drs_pkg::*;
#(
  parameter longint CONT_WAIT_CYC = DRS_CONT_WAIT_CYC,
  parameter longint QH_WAIT_CYC = DRS_QH_WAIT_CYC
)
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [DRS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DRS_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [DRS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DRS_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power stage and contactor feedback
  input wire logic trip_in,
  input wire logic contactor_closed,
  input wire logic defluxed,
  input wire logic stack_quenched,
  input wire logic zero_setpoint,
  input wire logic stop_complete,
  input wire logic config_reload,
  // Sequencer outputs
  output logic [2:0] main_state_code,
  output logic tripped,
  output logic running,
  output logic inching,
  output logic stopping,
  output logic contactor_cmd,
  output logic switch_on_enable,
  output logic switched_on,
  output logic ready,
  output logic healthy
);

  localparam logic [DRS_TIMER_W-1:0] CONT_LIMIT =
    DRS_TIMER_W'(CONT_WAIT_CYC - 64'd1);
  localparam logic [DRS_TIMER_W-1:0] QH_LIMIT =
    DRS_TIMER_W'(QH_WAIT_CYC - 64'd1);

  logic [DRS_DATA_W-1:0] cmd_r;
  logic [DRS_DATA_W-1:0] cfg_r;
  logic [DRS_DATA_W-1:0] status;

  logic run;
  logic inch;
  logic enable;
  logic coast_n;
  logic quick_n;
  logic fault_clr;
  logic qh_coast;
  logic idle;
  logic any_halt;
  logic lost_contactor;

  drs_state_e state_r;
  drs_state_e state_nxt;
  logic [DRS_T_N-1:0] cause;
  logic [DRS_T_N-1:0] cause_prev_r;
  logic [DRS_T_N-1:0] rise;

  logic run_prev_r;
  logic inch_prev_r;
  logic fault_clr_prev_r;
  logic run_fall;
  logic inch_fall;
  logic run_rise;
  logic inch_rise;
  logic fault_clr_rise;

  logic cont_timer_en;
  logic cont_expired;
  logic qh_timer_en;
  logic qh_expired;

  function automatic logic in_span(input drs_state_e s,
                                   input drs_state_e lo,
                                   input drs_state_e hi);
    return (s >= lo) && (s <= hi);
  endfunction : in_span

  drs_axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .cmd_r(cmd_r),
    .cfg_r(cfg_r),
    .status(status)
  );

  assign run = cmd_r[DRS_CMD_RUN];
  assign inch = cmd_r[DRS_CMD_INCH];
  assign enable = cmd_r[DRS_CMD_ENABLE];
  assign coast_n = cmd_r[DRS_CMD_COAST_N];
  assign quick_n = cmd_r[DRS_CMD_QUICK_N];
  assign fault_clr = cmd_r[DRS_CMD_FAULT_CLR];
  assign qh_coast = cfg_r[DRS_CFG_QH_COAST];
  assign idle = !run && !inch;
  assign any_halt = !coast_n || !quick_n;
  assign lost_contactor = !contactor_closed;

  // Contactor wait runs from entry to switched-on
  assign cont_timer_en = (state_r == DRS_SWITCHED_ON);
  assign qh_timer_en = (state_r == DRS_QHALT);

  drs_timer u_cont_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .count_en(cont_timer_en),
    .limit(CONT_LIMIT),
    .expired(cont_expired)
  );

  drs_timer u_qh_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .count_en(qh_timer_en),
    .limit(QH_LIMIT),
    .expired(qh_expired)
  );

  // Command edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_prev_r <= 1'b0;
      inch_prev_r <= 1'b0;
      fault_clr_prev_r <= 1'b0;
    end else if (ce) begin
      run_prev_r <= run;
      inch_prev_r <= inch;
      fault_clr_prev_r <= fault_clr;
    end
  end

  assign run_rise = run && !run_prev_r;
  assign inch_rise = inch && !inch_prev_r;
  assign run_fall = !run && run_prev_r;
  assign inch_fall = !inch && inch_prev_r;
  assign fault_clr_rise = fault_clr && !fault_clr_prev_r;

  // Cause of every transition, indexed by its number
  always_comb begin
    cause = '0;
    cause[DRS_T_SD_TRIP] = trip_in;
    cause[DRS_T_SD_SE] = idle && coast_n && quick_n;
    cause[DRS_T_SE_TRIP] = trip_in;
    cause[DRS_T_SE_SD] = any_halt;
    cause[DRS_T_SE_SO] = run || inch;
    cause[DRS_T_SO_TRIP] = trip_in || (cont_expired && lost_contactor);
    cause[DRS_T_SO_SD] = any_halt;
    cause[DRS_T_SO_SE] = idle;
    cause[DRS_T_SO_RDY] = contactor_closed && defluxed;
    cause[DRS_T_RDY_TRIP] = trip_in || lost_contactor;
    cause[DRS_T_RDY_SD] = any_halt;
    cause[DRS_T_RDY_SE] = idle;
    cause[DRS_T_RDY_EN] = enable;
    cause[DRS_T_EN_TRIP] = trip_in || lost_contactor;
    cause[DRS_T_EN_SD] = !coast_n;
    cause[DRS_T_EN_QH] = !quick_n;
    cause[DRS_T_EN_SE] = idle && stop_complete;
    cause[DRS_T_EN_RDY] = !enable;
    cause[DRS_T_QH_TRIP] = trip_in || lost_contactor;
    cause[DRS_T_QH_SD] = qh_expired || qh_coast || zero_setpoint;
    cause[DRS_T_TA_TD] = stack_quenched;
    cause[DRS_T_TD_SD] = !trip_in && fault_clr_rise;
  end

  // A cause already true on entry counts as a fresh rise
  assign rise = cause & ~cause_prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_prev_r <= '0;
    end else if (ce) begin
      if (config_reload || state_nxt != state_r) begin
        cause_prev_r <= '0;
      end else begin
        cause_prev_r <= cause;
      end
    end
  end

  // Priority chains, first match per state wins
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DRS_START_DIS: begin
        if (rise[DRS_T_SD_TRIP]) begin
          state_nxt = DRS_TRIP_ACTIVE;
        end else if (rise[DRS_T_SD_SE]) begin
          state_nxt = DRS_START_EN;
        end
      end
      DRS_START_EN: begin
        if (rise[DRS_T_SE_TRIP]) begin
          state_nxt = DRS_TRIP_ACTIVE;
        end else if (rise[DRS_T_SE_SD]) begin
          state_nxt = DRS_START_DIS;
        end else if (rise[DRS_T_SE_SO]) begin
          state_nxt = DRS_SWITCHED_ON;
        end
      end
      DRS_SWITCHED_ON: begin
        if (rise[DRS_T_SO_TRIP]) begin
          state_nxt = DRS_TRIP_ACTIVE;
        end else if (rise[DRS_T_SO_SD]) begin
          state_nxt = DRS_START_DIS;
        end else if (rise[DRS_T_SO_SE]) begin
          state_nxt = DRS_START_EN;
        end else if (rise[DRS_T_SO_RDY]) begin
          state_nxt = DRS_READY;
        end
      end
      DRS_READY: begin
        if (rise[DRS_T_RDY_TRIP]) begin
          state_nxt = DRS_TRIP_ACTIVE;
        end else if (rise[DRS_T_RDY_SD]) begin
          state_nxt = DRS_START_DIS;
        end else if (rise[DRS_T_RDY_SE]) begin
          state_nxt = DRS_START_EN;
        end else if (rise[DRS_T_RDY_EN]) begin
          state_nxt = DRS_ENABLED;
        end
      end
      DRS_ENABLED: begin
        if (rise[DRS_T_EN_TRIP]) begin
          state_nxt = DRS_TRIP_ACTIVE;
        end else if (rise[DRS_T_EN_SD]) begin
          state_nxt = DRS_START_DIS;
        end else if (rise[DRS_T_EN_QH]) begin
          state_nxt = DRS_QHALT;
        end else if (rise[DRS_T_EN_SE]) begin
          state_nxt = DRS_START_EN;
        end else if (rise[DRS_T_EN_RDY]) begin
          state_nxt = DRS_READY;
        end
      end
      DRS_QHALT: begin
        if (rise[DRS_T_QH_TRIP]) begin
          state_nxt = DRS_TRIP_ACTIVE;
        end else if (rise[DRS_T_QH_SD]) begin
          state_nxt = DRS_START_DIS;
        end
      end
      DRS_TRIP_ACTIVE: begin
        if (rise[DRS_T_TA_TD]) begin
          state_nxt = DRS_TRIPPED;
        end
      end
      DRS_TRIPPED: begin
        if (rise[DRS_T_TD_SD]) begin
          state_nxt = DRS_START_DIS;
        end
      end
      default: begin
        state_nxt = DRS_START_DIS;
      end
    endcase
    if (config_reload) begin
      state_nxt = DRS_START_DIS;
    end
  end

  // Single register update per enabled cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= DRS_START_DIS;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Outputs decoded from the next state so they line up with state_r
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_state_code <= 3'h0;
      tripped <= 1'b0;
      running <= 1'b0;
      switch_on_enable <= 1'b0;
      switched_on <= 1'b0;
      ready <= 1'b0;
    end else if (ce) begin
      main_state_code <= 3'(state_nxt);
      tripped <= in_span(state_nxt, DRS_TRIP_ACTIVE, DRS_TRIPPED);
      running <= (state_nxt == DRS_ENABLED);
      switch_on_enable <= in_span(state_nxt, DRS_START_EN,
                                  DRS_TRIP_ACTIVE);
      switched_on <= in_span(state_nxt, DRS_SWITCHED_ON,
                             DRS_TRIP_ACTIVE);
      ready <= in_span(state_nxt, DRS_READY, DRS_TRIP_ACTIVE);
    end
  end

  // Contactor holds its level through the two start states
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      contactor_cmd <= 1'b0;
    end else if (ce) begin
      if (state_nxt == DRS_TRIPPED) begin
        contactor_cmd <= 1'b0;
      end else if (in_span(state_nxt, DRS_SWITCHED_ON, DRS_TRIP_ACTIVE)) begin
        contactor_cmd <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      healthy <= 1'b1;
    end else if (ce) begin
      if (state_nxt == DRS_TRIP_ACTIVE) begin
        healthy <= 1'b0;
      end else if (state_nxt == DRS_TRIPPED) begin
        healthy <= healthy || idle;
      end else begin
        healthy <= 1'b1;
      end
    end
  end

  // Inch cycle ends on stop delay done or a run demand
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inching <= 1'b0;
    end else if (ce) begin
      if (state_nxt != DRS_ENABLED) begin
        inching <= 1'b0;
      end else if (inch_rise) begin
        inching <= 1'b1;
      end else if (inching && (stop_complete || run)) begin
        inching <= 1'b0;
      end
    end
  end

  // Stop cycle ends when stopping completes or a new demand arrives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stopping <= 1'b0;
    end else if (ce) begin
      if (state_nxt == DRS_QHALT) begin
        stopping <= 1'b1;
      end else if (state_nxt != DRS_ENABLED) begin
        stopping <= 1'b0;
      end else if (run_fall || inch_fall) begin
        stopping <= 1'b1;
      end else if (stop_complete || run_rise || inch_rise) begin
        stopping <= 1'b0;
      end
    end
  end

  always_comb begin
    status = '0;
    status[DRS_ST_CODE_LSB +: 3] = main_state_code;
    status[DRS_ST_TRIPPED] = tripped;
    status[DRS_ST_RUNNING] = running;
    status[DRS_ST_INCHING] = inching;
    status[DRS_ST_STOPPING] = stopping;
    status[DRS_ST_CONTACTOR] = contactor_cmd;
    status[DRS_ST_SW_ON_EN] = switch_on_enable;
    status[DRS_ST_SWITCHED_ON] = switched_on;
    status[DRS_ST_READY] = ready;
    status[DRS_ST_HEALTHY] = healthy;
  end

endmodule : drs_sequencer
`default_nettype wire

/* tb/drs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module drs_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Causes
  input wire logic config_reload,
  input wire logic stack_quenched,
  // State outputs
  input wire logic [2:0] main_state_code,
  input wire logic tripped,
  input wire logic running,
  input wire logic inching,
  input wire logic stopping,
  input wire logic contactor_cmd,
  input wire logic switch_on_enable,
  input wire logic switched_on,
  input wire logic ready,
  input wire logic healthy
);
  logic [2:0] c;
  assign c = main_state_code;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_ta_q;
    c == 3'h6 && stack_quenched && !config_reload;
  endsequence
  property p_trp;
    tripped == (c > 3'h5);
  endproperty
  property p_run;
    running == (c == 3'h4);
  endproperty
  property p_sen;
    switch_on_enable == (c inside {[3'h1:3'h6]});
  endproperty
  property p_swo;
    switched_on == (c inside {[3'h2:3'h6]});
  endproperty
  property p_rdy;
    ready == (c inside {[3'h3:3'h6]});
  endproperty
  property p_hlt;
    c != 3'h7 |-> healthy == (c != 3'h6);
  endproperty
  property p_ctr;
    c > 3'h1 |-> contactor_cmd == (c != 3'h7);
  endproperty
  property p_stp;
    c != 3'h4 |-> stopping == (c == 3'h5);
  endproperty
  property p_rld;
    config_reload |=> c == 3'h0;
  endproperty
  property p_ta;
    s_ta_q |=> c == 3'h7;
  endproperty
  property p_inc;
    c != 3'h4 |-> !inching;
  endproperty
  a_trp: assert property (p_trp) else $error("tripped wrong");
  a_run: assert property (p_run) else $error("running wrong");
  a_sen: assert property (p_sen) else $error("sw on en wrong");
  a_swo: assert property (p_swo) else $error("sw on wrong");
  a_rdy: assert property (p_rdy) else $error("ready wrong");
  a_hlt: assert property (p_hlt) else $error("healthy wrong");
  a_ctr: assert property (p_ctr) else $error("contactor wrong");
  a_stp: assert property (p_stp) else $error("stopping wrong");
  a_rld: assert property (p_rld) else $error("reload missed");
  a_ta: assert property (p_ta) else $error("quench missed");
  a_inc: assert property (p_inc) else $error("inching wrong");
endmodule : drs_assertions
bind drs_sequencer drs_assertions u_chk (.*);
`default_nettype wire

/* tb/drs_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module drs_partner (
  // Clock
  input wire logic aclk,
  // From drive
  input wire logic contactor_cmd,
  input wire logic tripped,
  // Fault injection and speed
  input wire logic stuck,
  input wire logic [3:0] dly,
  // To drive
  output logic contactor_closed = 1'b0,
  output logic defluxed = 1'b0,
  output logic stack_quenched = 1'b0
);
  logic [3:0] cnt_r = 4'h0;
  // Closes dly+1 cycles after command; stuck models a welded-open coil
  always_ff @(posedge aclk) begin
    cnt_r <= !contactor_cmd ? 4'h0 : cnt_r + 4'(cnt_r != dly);
    contactor_closed <= contactor_cmd && !stuck && cnt_r == dly;
    defluxed <= contactor_closed;
    stack_quenched <= tripped;
  end
endmodule : drs_partner
`default_nettype wire

/* tb/test_drive_run_sequencer_fsm.sv */
`timescale 1ns/1ps
`default_nettype none
module test_drive_run_sequencer_fsm;
  logic aclk = 0, aresetn = 0, ce = 1, config_reload = 0, trip_in = 0;
  logic zero_setpoint = 0, stop_complete = 0, stuck = 0;
  logic [3:0] dly, s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, contactor_closed, defluxed, stack_quenched;
  logic [2:0] main_state_code;
  logic tripped, running, inching, stopping, contactor_cmd;
  logic switch_on_enable, switched_on, ready, healthy;
  logic [33:0] exq[$], exp_v, got;
  int err_count = 0, cmp_count = 0;
  // Inching and stopping vary inside a stop; unmasked for the inch test
  logic [33:0] msk = 34'h3_FFFF_FF9F;
  always #10 aclk = ~aclk;
  drs_sequencer #(.CONT_WAIT_CYC(20), .QH_WAIT_CYC(50)) DUT (.*);
  drs_partner u_partner (.*);
  function automatic logic [33:0] st(input int c, input bit k, input bit h);
    logic [31:0] v;
    v = 32'(c);
    v[3] = c > 5;
    v[4] = c == 4;
    v[7] = (c < 2) ? k : (c < 7);
    v[8] = c > 0 && c < 7;
    v[9] = c > 1 && c < 7;
    v[10] = c > 2 && c < 7;
    v[11] = (c == 7) ? h : (c < 6);
    return {2'h0, v};
  endfunction : st
  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask : cy
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    exq.push_back({(a inside {4'h0, 4'h4, 4'h8}) ? 2'h0 : 2'h3, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    exq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask : rd
  always @(posedge aclk) begin
    if ((s_axi_rvalid && s_axi_rready) ||
        (s_axi_bvalid && s_axi_bready)) begin
      exp_v = exq.pop_front();
      got = s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0};
      cmp_count++;
      if ((got & msk) !== (exp_v & msk)) begin
        err_count++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp_v);
      end
    end
  end
  task automatic test_done;
    $display("Compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  initial begin
    void'($urandom(32'h3b24));
    dly = 4'($urandom_range(6, 1));
    cy(20);
    aresetn <= 1;
    cy(1);
    rd(4'h8, st(0, 0, 0));
    cy(1);
    rd(4'hC, {2'h3, 32'h0});
    wr(4'h0, 32'h18);
    cy(4);
    rd(4'h8, st(1, 0, 0));
    wr(4'h8, $urandom);
    cy(1);
    wr(4'hC, $urandom);
    rd(4'h8, st(1, 0, 0));
    wr(4'h0, 32'h19);
    cy(12);
    rd(4'h8, st(3, 0, 0));
    wr(4'h0, 32'h1D);
    cy(4);
    rd(4'h8, st(4, 0, 0));
    wr(4'h0, 32'h0D);
    cy(2);
    rd(4'h8, st(5, 0, 0));
    cy(60);
    rd(4'h8, st(0, 1, 0));
    wr(4'h0, 32'h18);
    cy(4);
    rd(4'h8, st(1, 1, 0));
    wr(4'h0, 32'h19);
    cy(12);
    trip_in <= 1;
    cy(6);
    rd(4'h8, st(7, 0, 0));
    wr(4'h0, 32'h18);
    cy(4);
    rd(4'h8, st(7, 0, 1));
    trip_in <= 0;
    wr(4'h0, 32'h38);
    cy(4);
    rd(4'h8, st(1, 0, 0));
    stuck <= 1;
    wr(4'h0, 32'h19);
    cy(4);
    rd(4'h8, st(2, 0, 0));
    cy(30);
    rd(4'h8, st(7, 0, 0));
    config_reload <= 1;
    cy(1);
    config_reload <= 0;
    cy(2);
    rd(4'h8, st(0, 0, 0));
    stuck <= 0;
    wr(4'h0, 32'h18);
    cy(4);
    wr(4'h0, 32'h10);
    cy(4);
    rd(4'h8, st(0, 0, 0));
    wr(4'h0, 32'h18);
    cy(1);
    wr(4'h0, 32'h19);
    cy(12);
    wr(4'h0, 32'h1D);
    cy(1);
    wr(4'h0, 32'h1E);
    msk <= '1;
    cy(2);
    rd(4'h8, st(4, 0, 0) | 34'h60);
    stop_complete <= 1;
    cy(2);
    rd(4'h8, st(4, 0, 0));
    wr(4'h0, 32'h1C);
    cy(2);
    rd(4'h8, st(1, 1, 0));
    cy(2);
    test_done();
  end
  initial begin
    cy(3000);
    err_count++;
    test_done();
  end
endmodule : test_drive_run_sequencer_fsm
`default_nettype wire
